/* File: design/line_alarm_pkg.sv */
// Constants and carrier types for the line alarm interrupt block.
package line_alarm_pkg;

  localparam int NUM_CH = 14;
  localparam logic [3:0] LAST_CH = 4'hD;

  // Register indices; the byte address is four times the index.
  localparam logic [3:0] ENA_IDX = 4'h4;
  localparam logic [3:0] STAT_IDX = 4'h5;
  localparam logic [3:0] CHG_IDX = 4'h6;
  localparam logic [7:0] GCTL_IDX = 8'hE0;
  localparam logic [7:0] GMON_IDX = 8'hE5;

  // Field positions.
  localparam int GIE_BIT = 0;
  localparam int CVSEL_BIT = 7;
  localparam int DRV_BIT = 6;
  localparam int FIFO_BIT = 5;
  localparam int CV_BIT = 4;
  localparam int AIS_BIT = 2;
  localparam int LOS_BIT = 1;
  localparam int PAT_BIT = 0;
  localparam logic [7:0] ALARM_MASK = 8'h77;
  localparam logic [7:0] REG_RST = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic drvFail;
    logic fifoLimit;
    logic codeViol;
    logic cntOvf;
    logic allOnes;
    logic sigLoss;
    logic patDet;
  } alarm_type;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_type;

endpackage

/* File: design/line_alarm_status_irq.sv */
// Per-channel alarm status, change and enable registers with interrupt.
//
// Behaviour
// - All-ones interrupt enable bit, RW, resets zero.
// - Signal-loss interrupt enable bit, RW, resets zero.
// - Pattern-detect interrupt enable bit, RW, resets zero.
// - Interrupt needs alarm enable and global enable.
// - Driver-fail flag follows driver failure continuously.
// - Driver-fail interrupt needs its enable and global.
// - FIFO limit flag follows pointer proximity.
// - Global select switches flag to counter overflow.
// - By default flag shows code violation events.
// - All-ones flag follows all-ones detection.
// - Signal-loss flag follows loss condition.
// - Status read-only, reserved bits zero, resets zero.
// - Enables for driver, FIFO, violation at 6,5,4.
// - Status changes set change bits, cleared on read.
//
// Design decision made here: register access over AXI4-Lite.
module line_alarm_status_irq
  import line_alarm_pkg::*;
(
  // Clock and reset.
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  // Alarm detector outputs, one group per channel.
  input  wire alarm_type [NUM_CH-1:0] alarmIn,
  // Register bus.
  input  wire axi_req_type            axiReq,
  output      axi_rsp_type            axiRsp,
  // Interrupt.
  output      logic                   irqOut
);

  typedef struct packed {
    alarm_type [NUM_CH-1:0] meta;
    alarm_type [NUM_CH-1:0] sync;
    logic [NUM_CH-1:0][7:0] stat;
    logic [NUM_CH-1:0][7:0] chg;
    logic [NUM_CH-1:0][7:0] ena;
    logic                   global_irq_en;
    logic                   cvSel;
    logic [7:0]             wIdx;
    logic                   awBad;
    logic                   awHave;
    logic [7:0]             wData;
    logic                   wStrb0;
    logic                   wHave;
    logic                   awRdy;
    logic                   wRdy;
    logic                   bValid;
    logic [1:0]             bResp;
    logic                   arRdy;
    logic                   rValid;
    logic [7:0]             rData;
    logic [1:0]             rResp;
    logic                   irq;
  } state_type;

  state_type s_r;
  state_type s_nxt;

  //////////////////////////////////////////////////////////////////////////

  // Builds a status byte; reserved bits stay zero.
  function automatic logic [7:0] compose(alarm_type a, logic sel);
    logic [7:0] v;
    v = REG_RST;
    v[DRV_BIT] = a.drvFail;
    v[FIFO_BIT] = a.fifoLimit;
    v[CV_BIT] = sel ? a.cntOvf : a.codeViol;
    v[AIS_BIT] = a.allOnes;
    v[LOS_BIT] = a.sigLoss;
    v[PAT_BIT] = a.patDet;
    return v;
  endfunction

  // Returns {hit, data} for a register index.
  function automatic logic [8:0] readReg(state_type st, logic [7:0] ix);
    logic [8:0] r;
    r = {1'b0, REG_RST};
    if (ix == GCTL_IDX) begin
      r = {1'b1, 8'(st.global_irq_en) << GIE_BIT};
    end else if (ix == GMON_IDX) begin
      r = {1'b1, 8'(st.cvSel) << CVSEL_BIT};
    end else if (ix[7:4] <= LAST_CH) begin
      case (ix[3:0])
        ENA_IDX: r = {1'b1, st.ena[ix[7:4]]};
        STAT_IDX: r = {1'b1, st.stat[ix[7:4]]};
        CHG_IDX: r = {1'b1, st.chg[ix[7:4]]};
        default: r = {1'b0, REG_RST};
      endcase
    end
    return r;
  endfunction

  // True when any channel holds an enabled change bit.
  function automatic logic anyPend(state_type st);
    logic p;
    p = 1'b0;
    for (int c = 0; c < NUM_CH; c++) begin
      p = p | (|(st.chg[c] & st.ena[c]));
    end
    return p;
  endfunction

  //////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic [NUM_CH-1:0][7:0] clr;
    logic [8:0]             rd;
    logic [8:0]             wr;
    logic                   wrFire;
    clr = '0;
    rd = '0;
    wr = '0;
    wrFire = 1'b0;
    s_nxt = s_r;

    // Two flip-flops before any logic reads the alarm inputs.
    s_nxt.meta = alarmIn;
    s_nxt.sync = s_r.meta;

    // Write: completes once both address and data are held.
    wrFire = s_r.awHave && s_r.wHave && !s_r.bValid;
    wr = readReg(s_r, s_r.wIdx);
    if (wrFire) begin
      s_nxt.awHave = 1'b0;
      s_nxt.wHave = 1'b0;
      s_nxt.bValid = 1'b1;
      s_nxt.bResp = (wr[8] && !s_r.awBad) ? RESP_OKAY : RESP_SLVERR;
      if (wr[8] && !s_r.awBad && s_r.wStrb0) begin
        if (s_r.wIdx == GCTL_IDX) begin
          s_nxt.global_irq_en = s_r.wData[GIE_BIT];
        end else if (s_r.wIdx == GMON_IDX) begin
          s_nxt.cvSel = s_r.wData[CVSEL_BIT];
        end else if (s_r.wIdx[3:0] == ENA_IDX) begin
          s_nxt.ena[s_r.wIdx[7:4]] = s_r.wData & ALARM_MASK;
        end else if (s_r.wIdx[3:0] == CHG_IDX) begin
          clr[s_r.wIdx[7:4]] = s_r.wData;
        end
      end
    end
    if (s_r.bValid && axiReq.bready) begin
      s_nxt.bValid = 1'b0;
    end
    if (axiReq.awvalid && s_r.awRdy) begin
      s_nxt.awHave = 1'b1;
      s_nxt.wIdx = axiReq.awaddr[9:2];
      s_nxt.awBad = |axiReq.awaddr[31:10];
    end
    if (axiReq.wvalid && s_r.wRdy) begin
      s_nxt.wHave = 1'b1;
      s_nxt.wData = axiReq.wdata[7:0];
      s_nxt.wStrb0 = axiReq.wstrb[0];
    end

    // Read: answer registered one edge after the address is taken.
    if (s_r.rValid && axiReq.rready) begin
      s_nxt.rValid = 1'b0;
    end
    if (axiReq.arvalid && s_r.arRdy) begin
      rd = readReg(s_r, axiReq.araddr[9:2]);
      if (|axiReq.araddr[31:10]) begin
        rd = '0;
      end
      s_nxt.rValid = 1'b1;
      s_nxt.rData = rd[7:0];
      s_nxt.rResp = rd[8] ? RESP_OKAY : RESP_SLVERR;
      if (rd[8] && axiReq.araddr[5:2] == CHG_IDX) begin
        clr[axiReq.araddr[9:6]] = clr[axiReq.araddr[9:6]] | rd[7:0];
      end
    end

    // Status tracks the alarms; a change sets its bit after clears.
    for (int c = 0; c < NUM_CH; c++) begin
      s_nxt.stat[c] = compose(s_r.sync[c], s_r.cvSel);
      s_nxt.chg[c] = (s_r.chg[c] & ~clr[c])
                   | (s_nxt.stat[c] ^ s_r.stat[c]);
    end

    s_nxt.awRdy = !s_nxt.awHave && !s_nxt.bValid;
    s_nxt.wRdy = !s_nxt.wHave && !s_nxt.bValid;
    s_nxt.arRdy = !s_nxt.rValid;
    s_nxt.irq = s_nxt.global_irq_en && anyPend(s_nxt);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////

  assign axiRsp.awready = s_r.awRdy;
  assign axiRsp.wready = s_r.wRdy;
  assign axiRsp.bvalid = s_r.bValid;
  assign axiRsp.bresp = s_r.bResp;
  assign axiRsp.arready = s_r.arRdy;
  assign axiRsp.rvalid = s_r.rValid;
  assign axiRsp.rdata = {24'h000000, s_r.rData};
  assign axiRsp.rresp = s_r.rResp;
  assign irqOut = s_r.irq;

  //////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic wrDone;
  assign wrDone = s_r.awHave && s_r.wHave && !s_r.bValid;

  chk_irq_needs_gie: assert property (
    irqOut |-> s_r.global_irq_en)
    else $error("Interrupt high with global enable clear.");

  chk_irq_needs_enable: assert property (
    irqOut |-> anyPend(s_r))
    else $error("Interrupt high with no enabled change bit.");

  chk_irq_raised: assert property (
    (s_r.global_irq_en && anyPend(s_r)) |-> irqOut)
    else $error("Enabled pending change did not raise interrupt.");

  // The bus answers a read one edge after it takes it, and a write one edge after it completes.
  chk_rd_answer: assert property (
    (axiReq.arvalid && axiRsp.arready) |=> axiRsp.rvalid)
    else $error("Read address taken without an answer.");

  chk_wr_answer: assert property (
    wrDone |=> axiRsp.bvalid)
    else $error("Write completed without a response.");

  for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
    sequence chgRead;
      axiReq.arvalid && s_r.arRdy
        && axiReq.araddr[31:2] == 30'({4'(g), CHG_IDX});
    endsequence
    sequence quietStat;
      s_r.stat[g] == $past(s_r.stat[g]);
    endsequence

    chk_stat_reserved: assert property (
      (s_r.stat[g] & ~ALARM_MASK) == 8'h00)
      else $error("Reserved status bit set.");

    chk_drv_follow: assert property (
      s_r.sync[g].drvFail |=> s_r.stat[g][DRV_BIT])
      else $error("Driver fail flag did not follow input.");

    chk_fifo_follow: assert property (
      !s_r.sync[g].fifoLimit |=> !s_r.stat[g][FIFO_BIT])
      else $error("FIFO limit flag did not follow input.");

    chk_ais_follow: assert property (
      s_r.sync[g].allOnes |=> s_r.stat[g][AIS_BIT])
      else $error("All-ones flag did not follow input.");

    chk_los_follow: assert property (
      $rose(alarmIn[g].sigLoss) ##1 alarmIn[g].sigLoss
        ##1 alarmIn[g].sigLoss |=> s_r.stat[g][LOS_BIT])
      else $error("Signal loss flag late.");

    chk_pat_follow: assert property (
      !s_r.sync[g].patDet |=> !s_r.stat[g][PAT_BIT])
      else $error("Pattern flag did not follow input.");

    chk_drv_clear: assert property (
      !s_r.sync[g].drvFail |=> !s_r.stat[g][DRV_BIT])
      else $error("Driver fail flag stayed set.");

    chk_cv_quiet: assert property (
      (!s_r.cvSel && !s_r.sync[g].codeViol) |=> !s_r.stat[g][CV_BIT])
      else $error("Violation flag set with no event.");

    chk_los_clear: assert property (
      !s_r.sync[g].sigLoss |=> !s_r.stat[g][LOS_BIT])
      else $error("Signal loss flag stayed set.");

    chk_cv_default: assert property (
      (!s_r.cvSel && s_r.sync[g].codeViol) |=> s_r.stat[g][CV_BIT])
      else $error("Violation flag missed an event.");

    chk_cv_overflow: assert property (
      s_r.cvSel |=> s_r.stat[g][CV_BIT] == $past(s_r.sync[g].cntOvf))
      else $error("Violation flag ignores overflow select.");

    chk_chg_set: assert property (
      !$stable(s_r.stat[g]) |->
        (s_r.chg[g] & (s_r.stat[g] ^ $past(s_r.stat[g])))
        == (s_r.stat[g] ^ $past(s_r.stat[g])))
      else $error("Status change did not set change bit.");

    chk_chg_read_clear: assert property (
      chgRead ##1 quietStat |-> s_r.rValid
        && s_r.rData == $past(s_r.chg[g]) && s_r.chg[g] == 8'h00)
      else $error("Change read did not return and clear.");

    chk_ena_write_only: assert property (
      !$stable(s_r.ena[g]) |-> $past(wrDone)
        && $past(s_r.wIdx) == {4'(g), ENA_IDX})
      else $error("Enable register changed without a write.");
  end

endmodule

/* File: sim/alarm_source_model.sv */
// Model of the per-channel alarm detectors that feed the block.
module alarm_source_model
  import line_alarm_pkg::*;
(
  // Clock and reset.
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  // Load request from the bench.
  input  wire logic                   load,
  input  wire logic [3:0]             chSel,
  input  wire alarm_type              lvl,
  // Detector levels.
  output      alarm_type [NUM_CH-1:0] alarmOut
);
  timeunit 1ns;
  timeprecision 100ps;

  // Detector levels stand until a new level is loaded.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alarmOut <= '0;
    end else if (load) begin
      alarmOut[chSel] <= lvl;
    end
  end
endmodule

/* File: sim/line_alarm_status_irq_tb_top.sv */
// Self-checking bench for the line alarm interrupt block.
module line_alarm_status_irq_tb_top
  import line_alarm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [31:0] GCTL_ADR = {22'h0, GCTL_IDX, 2'h0};
  localparam logic [31:0] GMON_ADR = {22'h0, GMON_IDX, 2'h0};

  logic                   core_clk;
  logic                   rst;
  alarm_type [NUM_CH-1:0] alarmIn;
  axi_req_type            axiReq;
  axi_rsp_type            axiRsp;
  logic                   irqOut;
  logic                   load;
  logic [3:0]             chSel;
  alarm_type              lvl;
  logic [1:0]             br;
  int                     nMismatch;
  int                     comparisons;

  line_alarm_status_irq u_line_alarm_status_irq (.core_clk(core_clk),
    .rst(rst), .alarmIn(alarmIn), .axiReq(axiReq), .axiRsp(axiRsp),
    .irqOut(irqOut));

  alarm_source_model u_alarm_source_model (.core_clk(core_clk), .rst(rst),
    .load(load), .chSel(chSel), .lvl(lvl), .alarmOut(alarmIn));

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (nMismatch == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] adr(input logic [3:0] ch,
                                      input logic [3:0] idx);
    return {22'h0, ch, idx, 2'h0};
  endfunction

  // Responses are sampled at the falling edge, where they are settled.
  task automatic wr(input logic [31:0] a, input logic [7:0] d,
                    output logic [1:0] resp);
    logic aw;
    logic w;
    logic b;
    @(posedge core_clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr  <= a;
    axiReq.wvalid  <= 1'b1;
    axiReq.wdata   <= {24'h0, d};
    axiReq.bready  <= 1'b1;
    do begin
      @(negedge core_clk);
      aw = axiRsp.awready;
      w = axiRsp.wready;
      b = axiRsp.bvalid;
      resp = axiRsp.bresp;
      @(posedge core_clk);
      if (aw) axiReq.awvalid <= 1'b0;
      if (w) axiReq.wvalid <= 1'b0;
    end while (!b);
    axiReq.bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d,
                    output logic [1:0] resp);
    logic ar;
    logic r;
    @(posedge core_clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr  <= a;
    axiReq.rready  <= 1'b1;
    do begin
      @(negedge core_clk);
      ar = axiRsp.arready;
      r = axiRsp.rvalid;
      d = axiRsp.rdata;
      resp = axiRsp.rresp;
      @(posedge core_clk);
      if (ar) axiReq.arvalid <= 1'b0;
    end while (!r);
    axiReq.rready <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [31:0] a,
                      input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  resp;
    rd(a, d, resp);
    check(what, d, exp);
    check("rd resp", resp, RESP_OKAY);
  endtask

  // Loads one channel's detector levels and waits for them to land.
  task automatic setAlarm(input logic [3:0] ch, input logic [6:0] v);
    @(posedge core_clk);
    load  <= 1'b1;
    chSel <= ch;
    lvl   <= alarm_type'(v);
    @(posedge core_clk);
    load <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic scnReset();
    rchk("enable", adr(4'h0, ENA_IDX), 32'h0);
    rchk("status", adr(4'h0, STAT_IDX), 32'h0);
    rchk("change", adr(4'h0, CHG_IDX), 32'h0);
  endtask

  task automatic scnEnable();
    for (int i = 0; i < 8; i++) begin
      wr(adr(LAST_CH, ENA_IDX), 8'h01 << i, br);
      check("wr resp", br, RESP_OKAY);
      rchk("en", adr(LAST_CH, ENA_IDX), (32'h1 << i) & 32'h77);
    end
  endtask

  task automatic scnStatus();
    setAlarm(4'h1, 7'h77);
    rchk("status", adr(4'h1, STAT_IDX), 32'h77);
    wr(adr(4'h1, STAT_IDX), 8'h00, br);
    rchk("status ro", adr(4'h1, STAT_IDX), 32'h77);
    wr(GMON_ADR, 8'h80, br);
    setAlarm(4'h1, 7'h6F);
    rchk("ovf sel", adr(4'h1, STAT_IDX), 32'h77);
    wr(GMON_ADR, 8'h00, br);
    setAlarm(4'h1, 7'h6F);
    rchk("viol sel", adr(4'h1, STAT_IDX), 32'h67);
  endtask

  task automatic scnIrq();
    wr(adr(4'h1, ENA_IDX), 8'h40, br);
    @(negedge core_clk);
    check("irq no global", irqOut, 1'b0);
    wr(GCTL_ADR, 8'h01, br);
    @(negedge core_clk);
    check("irq", irqOut, 1'b1);
    rchk("change", adr(4'h1, CHG_IDX), 32'h77);
    @(negedge core_clk);
    check("irq cleared", irqOut, 1'b0);
    setAlarm(4'h1, 7'h2F);
    @(negedge core_clk);
    check("irq again", irqOut, 1'b1);
    wr(adr(4'h1, ENA_IDX), 8'h37, br);
    @(negedge core_clk);
    check("irq masked", irqOut, 1'b0);
  endtask

  task automatic scnError();
    logic [31:0] d;
    logic [1:0]  r;
    rd(adr(4'h0, 4'h7), d, r);
    check("rd resp", r, RESP_SLVERR);
    check("rd data", d, 32'h0);
    wr(adr(4'hE, ENA_IDX), 8'h01, br);
    check("wr resp", br, RESP_SLVERR);
  endtask

  task automatic scnAccess();
    @(posedge core_clk);
    axiReq.wstrb <= 4'h0;
    wr(adr(4'h1, ENA_IDX), 8'h00, br);
    axiReq.wstrb <= 4'hF;
    check("strb resp", br, RESP_OKAY);
    rchk("strb en", adr(4'h1, ENA_IDX), 32'h37);
    wr(32'h0000_0400 | adr(4'h1, ENA_IDX), 8'h00, br);
    check("far resp", br, RESP_SLVERR);
    rchk("far en", adr(4'h1, ENA_IDX), 32'h37);
    wr(adr(4'h1, CHG_IDX), 8'h40, br);
    rchk("w1c", adr(4'h1, CHG_IDX), 32'h0);
    rchk("global en", GCTL_ADR, 32'h1);
    rchk("ovf select", GMON_ADR, 32'h0);
  endtask

  task automatic scnMidReset();
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rchk("en reset", adr(4'h1, ENA_IDX), 32'h0);
    rchk("stat reset", adr(4'h1, STAT_IDX), 32'h0);
    rchk("gie reset", GCTL_ADR, 32'h0);
    @(negedge core_clk);
    check("irq reset", irqOut, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial begin
    rst = 1'b1;
    axiReq = '0;
    axiReq.wstrb = 4'hF;
    load = 1'b0;
    chSel = 4'h0;
    lvl = '0;
    br = 2'h0;
    nMismatch = 0;
    comparisons = 0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    scnReset();
    scnEnable();
    scnStatus();
    scnIrq();
    scnAccess();
    scnError();
    scnMidReset();
    give_verdict();
  end

  // Cuts a hang short; the tests need well under a thousand cycles.
  initial begin
    repeat (4000) @(posedge core_clk);
    nMismatch++;
    give_verdict();
  end
endmodule
